// ==== core/cse_cmp_alu.sv ====
/*
  compare subtractor: flags of minuend - subtrahend - borrow.
  assumes the difference itself is wanted by nobody.
*/
module cse_cmp_alu (
  // operands and flags
  cse_cmp_if.alu cmp
);
  logic [cse_pkg::DATA_W-1:0] diff;
  logic [cse_pkg::DATA_W-1:0] a;
  logic [cse_pkg::DATA_W-1:0] b;
  logic [cse_pkg::DATA_W-1:0] borrows;

  assign a = cmp.minuend;
  assign b = cmp.subtrahend;
  // difference only feeds the flags, never a register
  assign diff = cmp.minuend - cmp.subtrahend - {7'h00, cmp.borrow_in};
  assign borrows = (~a & b) | (b & diff) | (diff & ~a);

  always_comb begin
    cmp.flags = '0;
    cmp.flags[cse_pkg::FLAG_C] = borrows[cse_pkg::SIGN_BIT];
    cmp.flags[cse_pkg::FLAG_H] = borrows[cse_pkg::HALF_BIT];
    cmp.flags[cse_pkg::FLAG_N] = diff[cse_pkg::SIGN_BIT];
    cmp.flags[cse_pkg::FLAG_V] =
      (a[cse_pkg::SIGN_BIT] & ~b[cse_pkg::SIGN_BIT] & ~diff[cse_pkg::SIGN_BIT]) |
      (~a[cse_pkg::SIGN_BIT] & b[cse_pkg::SIGN_BIT] & diff[cse_pkg::SIGN_BIT]);
    // with carry in, zero only stays set if it already was
    cmp.flags[cse_pkg::FLAG_Z] = (diff == 8'h00) & cmp.zero_in;
  end
endmodule // cse_cmp_alu

// ==== core/cse_cmp_if.sv ====
/*
  carrier between the execution control and the compare subtractor.
  assumes both ends sit on the same core clock.
*/
interface cse_cmp_if;
  logic [cse_pkg::DATA_W-1:0] minuend;
  logic [cse_pkg::DATA_W-1:0] subtrahend;
  logic borrow_in;
  logic zero_in;
  logic [cse_pkg::FLAG_W-1:0] flags;

  modport ctl (output minuend, output subtrahend, output borrow_in, output zero_in,
    input flags);
  modport alu (input minuend, input subtrahend, input borrow_in, input zero_in,
    output flags);
endinterface : cse_cmp_if

// ==== core/cse_exec.sv ====
/*
  execution of the compare and bit-skip instruction group.
  assumes operands, io byte and status flags come from same-clock core logic,
  and that the fetch unit tells whether the next instruction is two words.
*/
module cse_exec (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // instruction request
  input wire logic op_valid,
  input wire cse_pkg::cse_op_t op_code,
  output logic op_ready,
  // operands
  input wire logic [7:0] first_val,
  input wire logic [7:0] second_operand_register,
  input wire logic [7:0] imm_val,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] io_val,
  input wire logic next_two_word,
  // status flags in
  input wire logic carry_in,
  input wire logic zero_in,
  // results
  output logic done,
  output logic [1:0] pc_step,
  output logic flag_we,
  output logic [4:0] flags
);
  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic is_compare(input cse_pkg::cse_op_t op);
    return op == cse_pkg::OP_COMPARE || op == cse_pkg::OP_COMPARE_CARRY ||
      op == cse_pkg::OP_COMPARE_IMMEDIATE;
  endfunction

  function automatic logic skip_taken(input cse_pkg::cse_op_t op, input logic [7:0] rv,
    input logic [7:0] iv, input logic [2:0] sel);
    logic hit;
    hit = 1'b0;
    unique case (op)
      cse_pkg::OP_SKIP_REG_BIT_CLEAR: hit = ~rv[sel];
      cse_pkg::OP_SKIP_REG_BIT_SET: hit = rv[sel];
      cse_pkg::OP_SKIP_IO_BIT_CLEAR: hit = ~iv[sel];
      cse_pkg::OP_SKIP_IO_BIT_SET: hit = iv[sel];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ****************************************
  // compare datapath
  // ****************************************
  cse_cmp_if cmp ();
  cse_pkg::cse_regs_t cur_ff;
  cse_pkg::cse_regs_t nxt_cur;
  logic take;
  logic hit;

  assign take = op_valid & cur_ff.ready;
  assign hit = skip_taken(op_code, second_operand_register, io_val, bit_sel);

  assign cmp.minuend = first_val;
  assign cmp.subtrahend = (op_code == cse_pkg::OP_COMPARE_IMMEDIATE) ?
    imm_val : second_operand_register;
  assign cmp.borrow_in = (op_code == cse_pkg::OP_COMPARE_CARRY) & carry_in;
  assign cmp.zero_in = (op_code == cse_pkg::OP_COMPARE_CARRY) ? zero_in : 1'b1;

  cse_cmp_alu u_alu (
    .cmp(cmp)
  );

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.flag_we = 1'b0;
    unique case (cur_ff.st)
      cse_pkg::ST_IDLE: begin
        if (take) begin
          nxt_cur.done = 1'b1;
          nxt_cur.pc_step = cse_pkg::PC_STEP_NEXT;
          if (is_compare(op_code)) begin
            // single cycle, flags loaded, result dropped
            nxt_cur.flag_we = 1'b1;
            nxt_cur.flags = cmp.flags;
          end else if (hit) begin
            // skips never touch flags; extra cycles per skipped word
            nxt_cur.done = 1'b0;
            nxt_cur.ready = 1'b0;
            nxt_cur.two_word = next_two_word;
            nxt_cur.st = next_two_word ? cse_pkg::ST_SKIP_MID : cse_pkg::ST_SKIP_LAST;
          end
        end
      end
      cse_pkg::ST_SKIP_MID: begin
        nxt_cur.st = cse_pkg::ST_SKIP_LAST;
      end
      cse_pkg::ST_SKIP_LAST: begin
        nxt_cur.st = cse_pkg::ST_IDLE;
        nxt_cur.ready = 1'b1;
        nxt_cur.done = 1'b1;
        nxt_cur.pc_step = cur_ff.two_word ?
          cse_pkg::PC_STEP_SKIP2 : cse_pkg::PC_STEP_SKIP1;
      end
      default: begin
        // unused state code: recover to idle
        nxt_cur = cse_pkg::CSE_RST;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur_ff <= cse_pkg::CSE_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign op_ready = cur_ff.ready;
  assign done = cur_ff.done;
  assign pc_step = cur_ff.pc_step;
  assign flag_we = cur_ff.flag_we;
  assign flags = cur_ff.flags;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic take_reg_skip;
  logic take_io_skip;
  assign take_reg_skip = take && (op_code == cse_pkg::OP_SKIP_REG_BIT_CLEAR ||
    op_code == cse_pkg::OP_SKIP_REG_BIT_SET);
  assign take_io_skip = take && (op_code == cse_pkg::OP_SKIP_IO_BIT_CLEAR ||
    op_code == cse_pkg::OP_SKIP_IO_BIT_SET);

  cmp_plain_flags_a: assert property (
    take && op_code == cse_pkg::OP_COMPARE |=>
      done && flag_we && op_ready && pc_step == 2'h1 &&
      flags[cse_pkg::FLAG_Z] == ($past(first_val) == $past(second_operand_register)))
    else $error("plain compare flags or timing wrong");

  // plain compare must ignore the carry flag even when it is set
  cmp_no_carry_a: assert property (
    take && op_code == cse_pkg::OP_COMPARE |=>
      flags[cse_pkg::FLAG_C] == ($past(first_val) < $past(second_operand_register)))
    else $error("plain compare borrow wrong");

  cmp_carry_borrow_a: assert property (
    take && op_code == cse_pkg::OP_COMPARE_CARRY |=>
      done && flag_we && flags[cse_pkg::FLAG_C] ==
      ({1'b0, $past(first_val)} < {1'b0, $past(second_operand_register)} +
        {8'h00, $past(carry_in)}))
    else $error("compare with carry borrow wrong");

  // zero can only survive a chained compare, never be created by it
  cmp_zero_keep_a: assert property (
    take && op_code == cse_pkg::OP_COMPARE_CARRY |=>
      flags[cse_pkg::FLAG_Z] == ($past(zero_in) && 8'($past(first_val) -
        $past(second_operand_register) - {7'h00, $past(carry_in)}) == 8'h00))
    else $error("compare with carry zero wrong");

  cmp_imm_flags_a: assert property (
    take && op_code == cse_pkg::OP_COMPARE_IMMEDIATE |=>
      done && flag_we && flags[cse_pkg::FLAG_C] == ($past(first_val) < $past(imm_val)))
    else $error("immediate compare flags wrong");

  reg_clear_skip_a: assert property (
    take && op_code == cse_pkg::OP_SKIP_REG_BIT_CLEAR &&
      !second_operand_register[bit_sel] && !next_two_word |=>
      !done && !flag_we ##1 done && pc_step == 2'h2 && !flag_we)
    else $error("register bit clear skip wrong");

  reg_set_skip_a: assert property (
    take && op_code == cse_pkg::OP_SKIP_REG_BIT_SET &&
      second_operand_register[bit_sel] && next_two_word |=>
      (!done && !flag_we) [*2] ##1 done && pc_step == 2'h3)
    else $error("register bit set skip wrong");

  io_clear_skip_a: assert property (
    take && op_code == cse_pkg::OP_SKIP_IO_BIT_CLEAR && !io_val[bit_sel] &&
      next_two_word |=>
      (!done && !flag_we) [*2] ##1 done && pc_step == cse_pkg::PC_STEP_SKIP2)
    else $error("io bit clear skip wrong");

  io_set_noskip_a: assert property (
    take && op_code == cse_pkg::OP_SKIP_IO_BIT_SET && !io_val[bit_sel] |=>
      done && !flag_we && pc_step == 2'h1 && op_ready)
    else $error("io bit set not-taken wrong");

  io_set_skip_a: assert property (
    take && op_code == cse_pkg::OP_SKIP_IO_BIT_SET && io_val[bit_sel] &&
      !next_two_word |=> !done && !flag_we ##1 done && !flag_we &&
      pc_step == cse_pkg::PC_STEP_SKIP1 && op_ready)
    else $error("io bit set skip wrong");

  skip_quiet_a: assert property (
    !op_ready |-> !flag_we && $stable(flags))
    else $error("flags changed while skipping");

  flags_hold_a: assert property (
    !flag_we |-> $stable(flags))
    else $error("flags moved without a write");

  skip_busy_bound_a: assert property (
    $fell(op_ready) |-> ##[1:2] $rose(op_ready))
    else $error("skip lasted too long");

  noskip_one_cycle_a: assert property (
    (take_reg_skip || take_io_skip) && !hit |=> done && pc_step == 2'h1 && !flag_we)
    else $error("skip not taken should finish at once");

  cmp_seen_c: cover property (take && is_compare(op_code) ##1 done && flag_we);
  skip1_seen_c: cover property (take_reg_skip && hit && !next_two_word ##2 done);
  skip2_seen_c: cover property (take_io_skip && hit && next_two_word ##3 done);
  back_to_back_c: cover property (done && take);
  refused_c: cover property (op_valid && !op_ready);
endmodule // cse_exec

// ==== core/cse_pkg.sv ====
/*
  shared constants and types of the compare and skip execution block.
  assumes one core clock and a synchronous active high reset.
*/
package cse_pkg;
  // ****************************************
  // widths and flag positions
  // ****************************************
  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int FLAG_W = 5;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 4;
  localparam int HALF_BIT = 3;
  localparam int SIGN_BIT = 7;

  // ****************************************
  // program counter steps in words
  // ****************************************
  localparam logic [1:0] PC_STEP_NEXT = 2'h1;
  localparam logic [1:0] PC_STEP_SKIP1 = 2'h2;
  localparam logic [1:0] PC_STEP_SKIP2 = 2'h3;

  // ****************************************
  // instruction group
  // ****************************************
  typedef enum logic [2:0] {
    OP_COMPARE = 3'h0,
    OP_COMPARE_CARRY = 3'h1,
    OP_COMPARE_IMMEDIATE = 3'h2,
    OP_SKIP_REG_BIT_CLEAR = 3'h3,
    OP_SKIP_REG_BIT_SET = 3'h4,
    OP_SKIP_IO_BIT_CLEAR = 3'h5,
    OP_SKIP_IO_BIT_SET = 3'h6
  } cse_op_t;

  // gray along idle -> mid -> last
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SKIP_MID = 2'h1,
    ST_SKIP_LAST = 2'h3
  } cse_state_t;

  typedef struct packed {
    cse_state_t st;
    logic ready;
    logic done;
    logic flag_we;
    logic [FLAG_W-1:0] flags;
    logic [1:0] pc_step;
    logic two_word;
  } cse_regs_t;

  localparam cse_regs_t CSE_RST = '{
    st: ST_IDLE, ready: 1'b1, done: 1'b0, flag_we: 1'b0,
    flags: 5'h00, pc_step: 2'h1, two_word: 1'b0};
endpackage : cse_pkg

// ==== testbench/compare_and_skip_exec_test.sv ====
/*
  self-checking bench of the compare and skip block.
  assumes cse_exec and the program counter model; inputs move on the falling edge.
*/
module compare_and_skip_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  cse_pkg::cse_op_t op_code = cse_pkg::OP_COMPARE;
  logic [7:0] first_val = 8'h00, second_operand_register = 8'h00, imm_val = 8'h00;
  logic [7:0] io_val = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic next_two_word = 1'b0, carry_in = 1'b0, zero_in = 1'b0;
  logic op_ready, done, flag_we;
  logic [1:0] pc_step;
  logic [4:0] flags;
  logic [15:0] pc_ff, pc_exp = 16'h0000;
  int error_cnt = 0, n_checks = 0, cyc;
  always #4 mclk = ~mclk;
  cse_exec dut (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .op_ready(op_ready), .first_val(first_val), .imm_val(imm_val), .bit_sel(bit_sel),
    .second_operand_register(second_operand_register), .io_val(io_val),
    .next_two_word(next_two_word), .carry_in(carry_in), .zero_in(zero_in), .done(done),
    .pc_step(pc_step), .flag_we(flag_we), .flags(flags));
  cse_pc_model pcm (.mclk(mclk), .rst(rst), .done(done), .pc_step(pc_step), .pc_ff(pc_ff));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [4:0] sub_flags(logic [7:0] a, logic [7:0] b, logic c, logic z);
    logic [8:0] r;
    logic [4:0] h, f;
    r = {1'b0, a} - {1'b0, b} - {8'h00, c};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    f[cse_pkg::FLAG_C] = r[8];
    f[cse_pkg::FLAG_Z] = (r[7:0] == 8'h00) & z;
    f[cse_pkg::FLAG_N] = r[7];
    f[cse_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[cse_pkg::FLAG_H] = h[4];
    return f;
  endfunction
  // starts at a falling edge; hold keeps a compare pending while the block is busy
  // valid is only lowered on busy cycles without hold, so calls run back to back
  task automatic issue(cse_pkg::cse_op_t op, logic [7:0] a, logic [7:0] b, logic [7:0] k,
      logic [2:0] sel, logic [7:0] io, logic tw, logic hold);
    op_code = op;
    first_val = a;
    second_operand_register = b;
    imm_val = k;
    bit_sel = sel;
    io_val = io;
    next_two_word = tw;
    if (!op_valid) begin
      op_valid = 1'b1;
    end
    @(posedge mclk);
    cyc = 0;
    do begin
      @(negedge mclk);
      cyc++;
      if (done !== 1'b1) begin
        op_valid = hold;
        if (hold) begin
          op_code = cse_pkg::OP_COMPARE;
          second_operand_register = 8'h01;
        end
      end
    end while (done !== 1'b1 && cyc < 8);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_compare();
    logic [7:0] av[6] = '{8'h80, 8'h00, 8'h10, 8'h42, 8'h7f, 8'h10};
    logic [7:0] bv[6] = '{8'h01, 8'h01, 8'h01, 8'h42, 8'hff, 8'h0f};
    logic [4:0] fx;
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 6; i++) begin
        for (int o = 0; o < 3; o++) begin
          carry_in = c[0];
          zero_in = ~c[0];
          issue(cse_pkg::cse_op_t'(o), av[i], (o == 2) ? ~bv[i] : bv[i], bv[i], 3'h0,
            8'h00, 1'b0, 1'b0);
          fx = (o == 1) ? sub_flags(av[i], bv[i], c[0], ~c[0]) :
            sub_flags(av[i], bv[i], 1'b0, 1'b1);
          chk("cmp flags", {3'h0, fx}, {3'h0, flags});
          chk("cmp cycles", 8'h01, 8'(cyc));
          chk("cmp flag_we", 8'h01, {7'h00, flag_we});
          chk("cmp pc_step", 8'h01, {6'h00, pc_step});
          pc_exp += 16'h0001;
        end
      end
    end
  endtask
  task automatic t_skip();
    logic [7:0] pat, st;
    logic [2:0] sel;
    logic [4:0] f0;
    logic hit;
    for (int o = 3; o < 7; o++) begin
      for (int v = 0; v < 2; v++) begin
        for (int tw = 0; tw < 2; tw++) begin
          sel = 3'(o * 2 + v + tw);
          pat = (v == 1) ? (8'h01 << sel) : ~(8'h01 << sel);
          hit = (o == 3 || o == 5) ? (v == 0) : (v == 1);
          st = hit ? ((tw == 1) ? 8'h03 : 8'h02) : 8'h01;
          f0 = flags;
          issue(cse_pkg::cse_op_t'(o), 8'h00, (o < 5) ? pat : ~pat, 8'h00, sel,
            (o < 5) ? ~pat : pat, tw[0], v[0]);
          chk("skip cycles", st, 8'(cyc));
          chk("skip pc_step", st, {6'h00, pc_step});
          chk("skip flags", {3'h0, f0}, {3'h0, flags});
          chk("skip flag_we", 8'h00, {7'h00, flag_we});
          pc_exp += {8'h00, st};
        end
      end
    end
    op_valid = 1'b0;
    @(negedge mclk);
    chk("pc skip", pc_exp[7:0], pc_ff[7:0]);
  endtask
  // reset lands in the middle of a taken two-word skip
  task automatic t_reset();
    issue(cse_pkg::OP_COMPARE, 8'h00, 8'h01, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0);
    op_code = cse_pkg::OP_SKIP_IO_BIT_SET;
    io_val = 8'hff;
    next_two_word = 1'b1;
    op_valid = 1'b1;
    @(negedge mclk);
    op_valid = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk("rst flags", 8'h00, {3'h0, flags});
    chk("rst pc_step", 8'h01, {6'h00, pc_step});
    chk("rst ready", 8'h01, {7'h00, op_ready});
    rst = 1'b0;
    pc_exp = 16'h0000;
    issue(cse_pkg::OP_COMPARE, 8'h80, 8'h01, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0);
    chk("rst cmp flags", {3'h0, sub_flags(8'h80, 8'h01, 1'b0, 1'b1)}, {3'h0, flags});
    pc_exp += 16'h0001;
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    t_compare();
    t_skip();
    t_reset();
    op_valid = 1'b0;
    @(negedge mclk);
    chk("pc", pc_exp[7:0], pc_ff[7:0]);
    give_verdict();
  end
  // the whole run needs well under 1000 cycles
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule // compare_and_skip_exec_test

// ==== testbench/cse_pc_model.sv ====
/*
  program counter model beside the compare and skip block.
  assumes pc_step is valid whenever done is high.
*/
module cse_pc_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // block results
  input wire logic done,
  input wire logic [1:0] pc_step,
  // counter
  output logic [15:0] pc_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_ff <= 16'h0000;
    end else if (done) begin
      pc_ff <= pc_ff + {14'h0000, pc_step};
    end
  end
endmodule // cse_pc_model
